// ===== rtl/spewg_guard.sv
// power-state and command-acceptance control of the serial EEPROM
//
// Overview of operation
// - Supply above trigger leaves reset for standby with all state known.
// - Supply below trigger forces the reset state at once.
// - After reset the write enable latch is clear and the device idles.
// - Each falling chip select starts decoding a fresh opcode.
// - A completed write clears the write enable latch.
// - The self-timed write starts only on the closing chip-select rise.
// - Array accesses during a write cycle are ignored; it runs on.
// - Unknown opcodes are ignored and the output stays undriven.
// - Write-enable sets the latch and its status bit; write-disable clears.
// - Write-disable keeps writes refused until the next write-enable.
// - While writing only the status read is serviced.
// - The status busy flag is one exactly while a write cycle runs.
`timescale 1ns/100ps
`include "spewg_cfg.svh"
module spewg_guard
    import spewg_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = `SPEWG_WRITE_US * `SPEWG_CLK_MHZ
)
(
    // clock, reset, enable
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // supply detector
    input  wire logic       por_ok_i,
    // serial bus
    input  wire logic       cs_n_i,
    input  wire logic       sck_i,
    input  wire logic       si_i,
    output logic            so_o,
    output logic            so_oe_o,
    // state towards the array datapath
    output logic            write_start_o,
    output logic            write_is_status_o,
    output logic            busy_o,
    output logic            write_enable_latch_o,
    output logic            standby_o
);
    spewg_pin_if pin ();

    spewg_pin_sync u_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .raw_i      ({por_ok_i, si_i, sck_i, cs_n_i}),
        .pin        (pin)
    );

    // ==========================================================
    // state
    spewg_state_t             state_r,  state_nxt;
    spewg_kind_t              kind_r,   kind_nxt;
    logic [7:0]               shift_r,  shift_nxt;
    logic [5:0]               cnt_r,    cnt_nxt;
    logic [7:0]               out_r,    out_nxt;
    logic [2:0]               ocnt_r,   ocnt_nxt;
    logic                     so_r,     so_nxt;
    logic                     oe_r,     oe_nxt;
    logic                     latch_r,  latch_nxt;
    logic                     busy_r,   busy_nxt;
    logic [`SPEWG_TMR_W-1:0]  tmr_r,    tmr_nxt;
    logic                     start_r,  start_nxt;
    logic                     wsts_r,   wsts_nxt;
    logic [7:0]               op_w;
    logic [7:0]               status_w;
    logic [`SPEWG_TMR_W-1:0]  tmr_last;

    assign op_w     = {shift_r[6:0], pin.si};
    assign tmr_last = `SPEWG_TMR_W'(WRITE_CYCLES - 1);

    always_comb begin
        status_w = 8'h00;
        status_w[`SPEWG_ST_BUSY_BIT] = busy_r;
        status_w[`SPEWG_ST_LATCH_BIT] = latch_r;
    end

    // ==========================================================
    // next-state logic
    always_comb begin
        state_nxt = state_r;
        kind_nxt  = kind_r;
        shift_nxt = shift_r;
        cnt_nxt   = cnt_r;
        out_nxt   = out_r;
        ocnt_nxt  = ocnt_r;
        so_nxt    = so_r;
        oe_nxt    = oe_r;
        latch_nxt = latch_r;
        busy_nxt  = busy_r;
        tmr_nxt   = tmr_r;
        start_nxt = 1'b0;
        wsts_nxt  = wsts_r;

        // self-timed cycle runs whatever the bus does
        if (busy_r) begin
            if (tmr_r == tmr_last) begin
                busy_nxt = 1'b0;
                latch_nxt = 1'b0;
                tmr_nxt  = '0;
            end else begin
                tmr_nxt  = tmr_r + `SPEWG_TMR_W'(1);
            end
        end

        case (state_r)
            SPEWG_RESET: begin
                // wait for a quiet bus so a frame is never joined midway
                if (pin.cs_n) begin
                    state_nxt = SPEWG_STANDBY;
                end
            end
            SPEWG_STANDBY: begin
                if (pin.cs_fall) begin
                    state_nxt = SPEWG_OPCODE;
                    cnt_nxt   = '0;
                    kind_nxt  = SPEWG_K_NONE;
                end
            end
            SPEWG_OPCODE: begin
                if (pin.cs_rise) begin
                    state_nxt = SPEWG_STANDBY;
                end else if (pin.sck_rise) begin
                    shift_nxt = op_w;
                    cnt_nxt   = cnt_r + 6'h01;
                    if (cnt_r == `SPEWG_OPC_BITS - 6'h01) begin
                        state_nxt = SPEWG_BODY;
                        if (op_w == `SPEWG_OP_STATUS_RD) begin
                            state_nxt = SPEWG_STATUS_OUT;
                            out_nxt   = status_w;
                            ocnt_nxt  = '0;
                        end else if (busy_r) begin
                            state_nxt = SPEWG_IGNORE;
                        end else if (op_w == `SPEWG_OP_WRITE) begin
                            kind_nxt  = SPEWG_K_WRITE;
                        end else if (op_w == `SPEWG_OP_WRSR) begin
                            kind_nxt  = SPEWG_K_WRSR;
                        end else if (op_w == `SPEWG_OP_READ) begin
                            kind_nxt  = SPEWG_K_READ;
                        end else if (op_w != `SPEWG_OP_WR_ENABLE &&
                                     op_w != `SPEWG_OP_WR_DISABLE) begin
                            state_nxt = SPEWG_IGNORE;
                        end
                    end
                end
            end
            SPEWG_BODY: begin
                if (pin.cs_rise) begin
                    state_nxt = SPEWG_STANDBY;
                    // latch changes take effect only on a clean close
                    if (cnt_r == `SPEWG_OPC_BITS &&
                        shift_r == `SPEWG_OP_WR_ENABLE) begin
                        latch_nxt = 1'b1;
                    end
                    if (cnt_r == `SPEWG_OPC_BITS &&
                        shift_r == `SPEWG_OP_WR_DISABLE) begin
                        latch_nxt = 1'b0;
                    end
                    if (latch_r && !busy_r &&
                        ((kind_r == SPEWG_K_WRITE &&
                          cnt_r >= `SPEWG_WRITE_MIN_BITS &&
                          cnt_r[2:0] == 3'h0) ||
                         (kind_r == SPEWG_K_WRSR &&
                          cnt_r == `SPEWG_WRSR_BITS))) begin
                        busy_nxt  = 1'b1;
                        start_nxt = 1'b1;
                        wsts_nxt  = (kind_r == SPEWG_K_WRSR);
                        tmr_nxt   = '0;
                    end
                end else if (pin.sck_rise) begin
                    // count wraps back to 32 from 39, staying in a byte-aligned window
                    cnt_nxt = (cnt_r == `SPEWG_CNT_WRAP)
                            ? `SPEWG_WRITE_MIN_BITS
                            : cnt_r + 6'h01;
                end
            end
            SPEWG_STATUS_OUT: begin
                if (pin.cs_rise) begin
                    state_nxt = SPEWG_STANDBY;
                    oe_nxt    = 1'b0;
                end else if (pin.sck_fall) begin
                    oe_nxt   = 1'b1;
                    so_nxt   = out_r[7];
                    ocnt_nxt = ocnt_r + 3'h1;
                    // reload each byte so polling sees the live flags
                    out_nxt  = (ocnt_r == 3'h7) ? status_w
                                                : {out_r[6:0], 1'b0};
                end
            end
            SPEWG_IGNORE: begin
                oe_nxt = 1'b0;
                if (pin.cs_rise) begin
                    state_nxt = SPEWG_STANDBY;
                end
            end
            default: begin
                state_nxt = SPEWG_RESET;
            end
        endcase

        // brown-out wins over everything, including a running write
        if (!pin.por_ok) begin
            state_nxt = SPEWG_RESET;
            kind_nxt  = SPEWG_K_NONE;
            cnt_nxt   = '0;
            shift_nxt = '0;
            latch_nxt = 1'b0;
            busy_nxt  = 1'b0;
            tmr_nxt   = '0;
            start_nxt = 1'b0;
            oe_nxt    = 1'b0;
            so_nxt    = `SPEWG_SO_RST;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= SPEWG_RESET;
            kind_r  <= SPEWG_K_NONE;
            shift_r <= '0;
            cnt_r   <= '0;
            out_r   <= '0;
            ocnt_r  <= '0;
            so_r    <= `SPEWG_SO_RST;
            oe_r    <= 1'b0;
            latch_r <= 1'b0;
            busy_r  <= 1'b0;
            tmr_r   <= '0;
            start_r <= 1'b0;
            wsts_r  <= 1'b0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            kind_r  <= kind_nxt;
            shift_r <= shift_nxt;
            cnt_r   <= cnt_nxt;
            out_r   <= out_nxt;
            ocnt_r  <= ocnt_nxt;
            so_r    <= so_nxt;
            oe_r    <= oe_nxt;
            latch_r <= latch_nxt;
            busy_r  <= busy_nxt;
            tmr_r   <= tmr_nxt;
            start_r <= start_nxt;
            wsts_r  <= wsts_nxt;
        end
    end

    assign so_o                 = so_r;
    assign so_oe_o              = oe_r;
    assign write_start_o        = start_r;
    assign write_is_status_o    = wsts_r;
    assign busy_o               = busy_r;
    assign write_enable_latch_o = latch_r;
    assign standby_o            = (state_r == SPEWG_STANDBY) && !busy_r;
endmodule : spewg_guard

// ===== rtl/spewg_cfg.svh
// constants of the write guard: opcodes, status layout, timing
`ifndef SPEWG_CFG_SVH
`define SPEWG_CFG_SVH

// ==========================================================
// opcodes
`define SPEWG_OP_WRSR        8'h01
`define SPEWG_OP_WRITE       8'h02
`define SPEWG_OP_READ        8'h03
`define SPEWG_OP_WR_DISABLE  8'h04
`define SPEWG_OP_STATUS_RD   8'h05
`define SPEWG_OP_WR_ENABLE   8'h06

// ==========================================================
// status byte field positions
`define SPEWG_ST_BUSY_BIT    0
`define SPEWG_ST_LATCH_BIT   1

// ==========================================================
// frame bit counts
`define SPEWG_OPC_BITS       6'h08
`define SPEWG_WRSR_BITS      6'h10
`define SPEWG_WRITE_MIN_BITS 6'h20
`define SPEWG_CNT_WRAP       6'h27

// ==========================================================
// timing
`define SPEWG_CLK_MHZ        25
`define SPEWG_WRITE_US       5000
`define SPEWG_TMR_W          20

// ==========================================================
// reset values
`define SPEWG_PIN_RST        4'h1
`define SPEWG_SO_RST         1'b0

`endif

// ===== rtl/spewg_pkg.sv
// types shared by the write guard modules
package spewg_pkg;

    typedef enum logic [2:0] {
        SPEWG_RESET,
        SPEWG_STANDBY,
        SPEWG_OPCODE,
        SPEWG_BODY,
        SPEWG_STATUS_OUT,
        SPEWG_IGNORE
    } spewg_state_t;

    typedef enum logic [1:0] {
        SPEWG_K_NONE,
        SPEWG_K_WRITE,
        SPEWG_K_WRSR,
        SPEWG_K_READ
    } spewg_kind_t;

endpackage : spewg_pkg

// ===== rtl/spewg_pin_if.sv
// synchronised pin levels and edge events from the pin stage to the core
`timescale 1ns/100ps
interface spewg_pin_if;
    logic cs_n;
    logic si;
    logic por_ok;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;

    modport pins (output cs_n, si, por_ok, sck_rise, sck_fall, cs_fall,
                  cs_rise);
    modport core (input  cs_n, si, por_ok, sck_rise, sck_fall, cs_fall,
                  cs_rise);
endinterface : spewg_pin_if

// ===== rtl/spewg_pin_sync.sv
// two-flop synchroniser and edge finder for the serial pins
`timescale 1ns/100ps
`include "spewg_cfg.svh"
module spewg_pin_sync
    import spewg_pkg::*;
(
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // raw pins, bit order {por_ok, si, sck, cs_n}
    input  wire logic [3:0] raw_i,
    // synchronised view
    spewg_pin_if.pins       pin
);
    logic [3:0] meta_r;
    logic [3:0] sync_r;
    logic [3:0] prev_r;
    logic [3:0] meta_nxt;
    logic [3:0] sync_nxt;
    logic [3:0] prev_nxt;

    // ==========================================================
    // per-bit stages; meta_r feeds sync_r only
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_bit
            always_comb begin
                meta_nxt[g] = raw_i[g];
                sync_nxt[g] = meta_r[g];
                prev_nxt[g] = sync_r[g];
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= `SPEWG_PIN_RST;
            sync_r <= `SPEWG_PIN_RST;
            prev_r <= `SPEWG_PIN_RST;
        end else if (ce_i) begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    // ==========================================================
    // edges are seen in the same cycle as the synchronised level
    assign pin.cs_n     = sync_r[0];
    assign pin.si       = sync_r[2];
    assign pin.por_ok   = sync_r[3];
    assign pin.sck_rise =  sync_r[1] & ~prev_r[1];
    assign pin.sck_fall = ~sync_r[1] &  prev_r[1];
    assign pin.cs_fall  = ~sync_r[0] &  prev_r[0];
    assign pin.cs_rise  =  sync_r[0] & ~prev_r[0];
endmodule : spewg_pin_sync

// ===== test/spewg_guard_chk.sv
// port-level assertion checker of the write guard, bound to its top
`timescale 1ns/100ps
module spewg_guard_chk
    import spewg_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = 600
)
(
    // clock, reset, enable
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // supply and serial bus
    input wire logic por_ok_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic so_o,
    input wire logic so_oe_o,
    // state towards the array
    input wire logic write_start_o,
    input wire logic write_is_status_o,
    input wire logic busy_o,
    input wire logic write_enable_latch_o,
    input wire logic standby_o
);
    // ==========================================================
    // length of the current busy run
    logic [19:0] run_r;
    logic [19:0] run_nxt;
    always_comb run_nxt = busy_o ? run_r + 20'h00001 : 20'h00000;
    always_ff @(posedge core_clk_i or posedge rst_i)
        if (rst_i) run_r <= 20'h00000;
        else       run_r <= run_nxt;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // ==========================================================
    // properties
    sequence s_low_supply;
        !por_ok_i [*4];
    endsequence
    sequence s_busy_run;
        busy_o ##1 busy_o [*8];
    endsequence
    property p_por_drop;
        s_low_supply |-> !write_enable_latch_o && !busy_o && !standby_o;
    endproperty
    property p_start_cs;
        write_start_o |-> cs_n_i && write_enable_latch_o && !$past(busy_o);
    endproperty
    property p_start_busy;
        write_start_o |-> s_busy_run;
    endproperty
    property p_start_pulse;
        write_start_o |=> !write_start_o;
    endproperty
    property p_busy_len;
        $fell(busy_o) && por_ok_i |-> run_r == WRITE_CYCLES;
    endproperty
    property p_done_latch;
        $fell(busy_o) |-> !write_enable_latch_o;
    endproperty
    property p_latch_set;
        $rose(write_enable_latch_o) |-> cs_n_i && !busy_o;
    endproperty
    property p_oe_frame;
        $rose(so_oe_o) |-> !cs_n_i;
    endproperty

    a_por_drop: assert property (p_por_drop)
        else $error("state kept with supply low");
    a_start_cs: assert property (p_start_cs)
        else $error("write start outside a closed enabled frame");
    a_start_busy: assert property (p_start_busy)
        else $error("busy not held after write start");
    a_start_pulse: assert property (p_start_pulse)
        else $error("write start longer than one cycle");
    a_busy_len: assert property (p_busy_len)
        else $error("write cycle length wrong");
    a_done_latch: assert property (p_done_latch)
        else $error("latch still set after write");
    a_latch_set: assert property (p_latch_set)
        else $error("latch set outside frame end or while busy");
    a_oe_frame: assert property (p_oe_frame)
        else $error("output driven outside a frame");
endmodule : spewg_guard_chk

bind spewg_guard spewg_guard_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.*);

// ===== test/spewg_host_model.sv
// host bus controller model: mode 0 frames, link clock only in frames
`timescale 1ns/100ps
module spewg_host_model (
    // clock and device output
    input  wire logic core_clk_i,
    input  wire logic so_i,
    input  wire logic so_oe_i,
    // serial bus towards the device
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o
);
    // half link period in core cycles; 4 gives 160 ns, raise for a slow host
    int half = 4;

    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        si_o   = 1'b0;
    end

    // sends n bits of d msb first; bits 8..15 come back in rx
    task automatic xfer(input logic [31:0] d, input int n,
                        output logic [7:0] rx);
        int i;
        rx = 8'h00;
        @(posedge core_clk_i);
        cs_n_o <= 1'b0;
        for (i = 0; i < n; i++) begin
            si_o <= d[31-i];
            repeat (half) @(posedge core_clk_i);
            sck_o <= 1'b1;
            if (i > 7 && i < 16)
                rx = {rx[6:0], so_oe_i ? so_i : 1'bx};
            repeat (half) @(posedge core_clk_i);
            sck_o <= 1'b0;
        end
        repeat (half) @(posedge core_clk_i);
        cs_n_o <= 1'b1;
        si_o   <= ~si_o;
        repeat (6) @(posedge core_clk_i);
    endtask : xfer
endmodule : spewg_host_model

// ===== test/spewg_guard_tb.sv
// self-checking bench of the write guard
`timescale 1ns/100ps
`include "spewg_cfg.svh"
`define CHK(g, e) \
    begin \
        num_checks++; \
        if ((g) !== (e)) begin \
            err_count++; \
            $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); \
        end \
    end
module spewg_guard_tb;
    import spewg_pkg::*;
    localparam int unsigned WCYC = 600;
    localparam logic [7:0]  OP_WR_EN  = `SPEWG_OP_WR_ENABLE;
    localparam logic [7:0]  OP_WR_DIS = `SPEWG_OP_WR_DISABLE;
    localparam logic [7:0]  OP_ST_RD  = `SPEWG_OP_STATUS_RD;
    localparam logic [31:0] WRIT = {`SPEWG_OP_WRITE, 24'h12345A};
    localparam logic [31:0] WRSR = {`SPEWG_OP_WRSR, 8'h0C, 16'h0000};
    logic       core_clk_i;
    logic       rst_i;
    logic       ce_i;
    logic       por_ok_i;
    logic       cs_n_i;
    logic       sck_i;
    logic       si_i;
    logic       so_o;
    logic       so_oe_o;
    logic       write_start_o;
    logic       write_is_status_o;
    logic       busy_o;
    logic       write_enable_latch_o;
    logic       standby_o;
    logic [7:0] rx;
    int         err_count = 0;
    int         num_checks = 0;
    int         starts = 0;
    int         oe_cnt = 0;
    int         n0;

    spewg_guard #(.WRITE_CYCLES(WCYC)) dut (.*);
    spewg_host_model u_host (
        .core_clk_i (core_clk_i),
        .so_i       (so_o),
        .so_oe_i    (so_oe_o),
        .cs_n_o     (cs_n_i),
        .sck_o      (sck_i),
        .si_o       (si_i)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i) begin
        if (write_start_o === 1'b1) starts++;
        if (so_oe_o === 1'b1) oe_cnt++;
    end

    // ==========================================================
    // helpers
    task automatic send(input logic [31:0] d, input int n);
        u_host.xfer(d, n, rx);
    endtask : send
    task automatic status(input logic [7:0] e);
        send({OP_ST_RD, 24'h0}, 16);
        `CHK(rx, e)
    endtask : status
    task automatic wait_for(input bit stby);
        int i;
        for (i = 0; i < 2000; i++) begin
            if (stby ? standby_o === 1'b1 : busy_o === 1'b0) break;
            @(posedge core_clk_i);
        end
    endtask : wait_for
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    // ==========================================================
    // scenarios
    task automatic t_power_up();
        wait_for(1);
        `CHK(standby_o, 1'b1)
        `CHK(write_enable_latch_o, 1'b0)
        status(8'h00);
        $display("test power_up done");
    endtask : t_power_up
    task automatic t_latch();
        n0 = starts;
        send(WRIT, 32);
        `CHK(starts, n0)
        send({OP_WR_EN, 24'h0}, 8);
        `CHK(write_enable_latch_o, 1'b1)
        status(8'h02);
        send({OP_WR_DIS, 24'h0}, 8);
        `CHK(write_enable_latch_o, 1'b0)
        send(WRIT, 32);
        `CHK(starts, n0)
        $display("test latch done");
    endtask : t_latch
    task automatic t_write(input logic [31:0] d, input int n, input bit st);
        n0 = starts;
        send({OP_WR_EN, 24'h0}, 8);
        send(d, n);
        `CHK(starts, n0 + 1)
        `CHK(write_is_status_o, st)
        `CHK(busy_o, 1'b1)
        status(8'h03);
        send({OP_WR_DIS, 24'h0}, 8);
        `CHK(write_enable_latch_o, 1'b1)
        send(WRIT, 32);
        `CHK(starts, n0 + 1)
        wait_for(0);
        `CHK(write_enable_latch_o, 1'b0)
        status(8'h00);
        $display("test write done");
    endtask : t_write
    task automatic t_short();
        n0 = starts;
        send({OP_WR_EN, 24'h0}, 8);
        send(WRIT, 20);
        send(WRSR, 12);
        send(WRSR, 24);
        `CHK(starts, n0)
        $display("test short done");
    endtask : t_short
    task automatic t_invalid();
        logic [7:0] ops [4] = '{8'h00, 8'h07, 8'hA5, 8'hFF};
        n0 = oe_cnt;
        foreach (ops[k]) begin
            send({ops[k], 24'h0}, 16);
            `CHK(oe_cnt, n0)
            `CHK(write_enable_latch_o, 1'b1)
        end
        // a read is decoded but must neither start a write nor touch the latch
        send({`SPEWG_OP_READ, 24'h0}, 32);
        `CHK(busy_o, 1'b0)
        `CHK(write_enable_latch_o, 1'b1)
        $display("test invalid done");
    endtask : t_invalid
    task automatic t_brownout();
        send({OP_WR_EN, 24'h0}, 8);
        send(WRIT, 32);
        repeat (40) @(posedge core_clk_i);
        por_ok_i <= 1'b0;
        repeat (10) @(posedge core_clk_i);
        `CHK(busy_o, 1'b0)
        `CHK(write_enable_latch_o, 1'b0)
        `CHK(standby_o, 1'b0)
        por_ok_i <= 1'b1;
        wait_for(1);
        `CHK(standby_o, 1'b1)
        status(8'h00);
        $display("test brownout done");
    endtask : t_brownout

    // ==========================================================
    // main sequence
    initial begin
        rst_i    = 1'b1;
        ce_i     = 1'b1;
        por_ok_i = 1'b1;
        repeat (16) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_power_up();
        t_latch();
        t_write(WRIT, 32, 1'b0);
        u_host.half = 6;
        t_write(WRSR, 16, 1'b1);
        u_host.half = 4;
        t_short();
        t_invalid();
        t_brownout();
        results();
    end

    // about 30 frames of at most 400 cycles plus three write cycles fit well inside
    initial begin
        repeat (60000) @(posedge core_clk_i);
        err_count++;
        results();
    end
endmodule : spewg_guard_tb
